// file: rtl/mqrps_top.sv
// read port of a multi-queue buffer: queue select, fallthrough, flag bus
// assumes one free-running read clock and a reader that keeps its strobes apart
`timescale 1ns/1ps
`include "mqrps_defines.svh"

module mqrps_top
    import mqrps_pkg::*;
(
    // clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst_n,
    // static configuration
    input  wire logic [2:0]                        device_id,
    input  wire logic                              packet_mode,
    input  wire logic                              polled_flag_mode,
    input  wire logic                              serial_load_done_out,
    // fill side shared by all queues
    input  wire logic                              wr_en,
    input  wire logic [3:0]                        wr_queue,
    input  wire logic [`MQRPS_DATA_W-1:0]          wr_data,
    // reader controls
    input  wire logic                              read_queue_select_strobe,
    input  wire logic                              flag_sector_strobe,
    input  wire logic [`MQRPS_ADDR_W-1:0]          read_address_bus,
    input  wire logic                              read_en_n,
    input  wire logic                              output_en_n,
    input  wire logic                              expansion_token_in,
    // read data
    output logic      [`MQRPS_DATA_W-1:0]          q_out,
    output logic                                   q_out_oe,
    // flags
    output logic                                   output_valid_flag_n,
    output logic                                   almost_empty_flag_n,
    output logic                                   packet_ready_flag_n,
    output logic      [`MQRPS_FLAG_W-1:0]          almost_empty_flag_bus,
    output logic      [`MQRPS_FLAG_W-1:0]          packet_ready_flag_bus,
    output logic                                   flag_poll_sync,
    output logic                                   expansion_token_out
);
    // ----------------------------------------------------------------
    // queue array
    // ----------------------------------------------------------------
    logic [`MQRPS_DATA_W-1:0]    head  [`MQRPS_NUM_QUEUES];
    logic [`MQRPS_PTR_W:0]       lvl   [`MQRPS_NUM_QUEUES];
    logic [`MQRPS_NUM_QUEUES-1:0] pkt, q_rd, ae_vec, pr_vec;

    logic [3:0]                  rq_q, rq_d;
    logic                        nullq_q, nullq_d;
    logic                        mine_q, mine_d;
    logic [3:0]                  oq_q, oq_d;
    mqrps_sel_t                  st_q, st_d;
    logic [`MQRPS_DATA_W-1:0]    dout_q, dout_d;
    logic                        ov_q, ov_d;
    logic                        sec_q, sec_d;
    logic [`MQRPS_FLAG_W-1:0]    aeb_q, aeb_d, prb_q, prb_d;
    logic                        sync_q, sync_d;
    logic                        ae_q, ae_d, pr_q, pr_d, tok_q, tok_d;
    logic                        addr_mine, cur_empty;
    logic [3:0]                  src_q;

    for (genvar g = 0; g < `MQRPS_NUM_QUEUES; g++) begin : g_q
        mqrps_queue u_queue (
            .clk_sys   (clk_sys),
            .rst_n     (rst_n),
            .wr_en     (wr_en && (wr_queue == 4'(g))),
            .wr_data   (wr_data),
            .wr_eop    (packet_mode && wr_data[`MQRPS_MARK_LSB+1]),
            .rd_en     (q_rd[g]),
            .rd_eop    (packet_mode && head[g][`MQRPS_MARK_LSB+1]),
            .head_data (head[g]),
            .level     (lvl[g]),
            .pkt_avail (pkt[g])
        );
        assign ae_vec[g] = (lvl[g] <= `MQRPS_AE_LEVEL);
        assign pr_vec[g] = pkt[g];
    end

    // device code match on the top address bits
    assign addr_mine = (read_address_bus[`MQRPS_DEV_MSB:`MQRPS_DEV_LSB] == device_id);

    // ----------------------------------------------------------------
    // queue selection and fallthrough sequencing
    // ----------------------------------------------------------------
    // selection ignores read enable, as the reader may switch at any time
    always_comb begin
        rq_d    = rq_q;
        nullq_d = nullq_q;
        mine_d  = mine_q;
        oq_d    = oq_q;
        st_d    = st_q;
        if (read_queue_select_strobe) begin
            oq_d    = rq_q;
            mine_d  = addr_mine;
            rq_d    = read_address_bus[`MQRPS_QIDX_MSB:0];
            nullq_d = read_address_bus[`MQRPS_NULL_BIT];
            st_d    = MQRPS_ST_OLD;
        end else begin
            case (st_q)
                MQRPS_ST_IDLE: st_d = MQRPS_ST_IDLE;
                MQRPS_ST_OLD:  st_d = MQRPS_ST_NEW;
                MQRPS_ST_NEW:  st_d = MQRPS_ST_IDLE;
                default:       st_d = MQRPS_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rq_q    <= `MQRPS_RST_QIDX;
            oq_q    <= `MQRPS_RST_QIDX;
            nullq_q <= 1'b1;
            mine_q  <= 1'b0;
            st_q    <= MQRPS_ST_IDLE;
        end else begin
            rq_q    <= rq_d;
            oq_q    <= oq_d;
            nullq_q <= nullq_d;
            mine_q  <= mine_d;
            st_q    <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // data output path
    // ----------------------------------------------------------------
    // the edge after selection still drains the previous queue
    assign src_q     = (st_q == MQRPS_ST_OLD) ? oq_q : rq_q;
    assign cur_empty = (lvl[src_q] == '0);

    always_comb begin
        dout_d = dout_q;
        ov_d   = ov_q;
        q_rd   = '0;
        if (!mine_q || (nullq_q && st_q != MQRPS_ST_OLD)) begin
            ov_d = 1'b0;                                  // null: no pointer moves
        end else if (st_q == MQRPS_ST_OLD || st_q == MQRPS_ST_NEW) begin
            // forced words regardless of read enable
            if (!cur_empty) begin
                dout_d      = head[src_q];
                q_rd[src_q] = 1'b1;
            end
            ov_d = !cur_empty;
        end else if ((!read_en_n && !output_en_n) || !ov_q) begin
            // normal read, or fallthrough refill when output is stale
            if (!cur_empty) begin
                dout_d      = head[src_q];
                q_rd[src_q] = 1'b1;
            end
            ov_d = !cur_empty;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dout_q <= '0;
            ov_q   <= 1'b0;
        end else begin
            dout_q <= dout_d;
            ov_q   <= ov_d;
        end
    end

    // top four bits carry packet markers in packet mode
    assign q_out               = dout_q;
    assign q_out_oe            = !output_en_n && mine_q;
    assign output_valid_flag_n = !ov_q;

    // ----------------------------------------------------------------
    // flag bus and discrete flags
    // ----------------------------------------------------------------
    always_comb begin
        sec_d  = sec_q;
        sync_d = 1'b0;
        if (polled_flag_mode) begin
            sec_d  = !sec_q;
            sync_d = sec_q;                               // sector 0 comes up next
        end else if (flag_sector_strobe && addr_mine) begin
            sec_d = read_address_bus[0];
        end
        aeb_d = ~ae_vec[sec_d*`MQRPS_FLAG_W +: `MQRPS_FLAG_W];
        prb_d = ~pr_vec[sec_d*`MQRPS_FLAG_W +: `MQRPS_FLAG_W];
        ae_d  = !(ae_vec[rq_q] && !nullq_q);
        pr_d  = !(packet_mode && pr_vec[rq_q] && !nullq_q);
        tok_d = expansion_token_in;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sec_q  <= 1'b0;
            sync_q <= 1'b0;
            aeb_q  <= `MQRPS_RST_FLAGS;
            prb_q  <= `MQRPS_RST_FLAGS;
            ae_q   <= 1'b1;
            pr_q   <= 1'b1;
            tok_q  <= 1'b0;
        end else begin
            sec_q  <= sec_d;
            sync_q <= sync_d;
            aeb_q  <= aeb_d;
            prb_q  <= prb_d;
            ae_q   <= ae_d;
            pr_q   <= pr_d;
            tok_q  <= tok_d;
        end
    end

    assign almost_empty_flag_n   = ae_q;
    assign packet_ready_flag_n   = pr_q;
    assign almost_empty_flag_bus = packet_mode ? `MQRPS_RST_FLAGS : aeb_q;
    assign packet_ready_flag_bus = packet_mode ? prb_q : `MQRPS_RST_FLAGS;
    assign flag_poll_sync        = sync_q;
    assign expansion_token_out   = tok_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_sel_capture: assert property (read_queue_select_strobe |=>
        rq_q == $past(read_address_bus[3:0])) else $error("queue not captured");
    a_null_capture: assert property (read_queue_select_strobe |=>
        nullq_q == $past(read_address_bus[4])) else $error("null bit lost");
    a_dev_match: assert property (read_queue_select_strobe |=>
        mine_q == ($past(read_address_bus[7:5]) == device_id)) else $error("device match");
    a_first_word_fallthrough_seq: assert property (read_queue_select_strobe ##1 !read_queue_select_strobe
        |-> st_q == MQRPS_ST_OLD ##1 st_q == MQRPS_ST_NEW) else $error("first_word_fallthrough order");
    a_old_src: assert property (st_q == MQRPS_ST_OLD && mine_q && lvl[oq_q] != '0
        |=> q_out == $past(head[oq_q])) else $error("old queue word missing");
    a_null_hold: assert property (nullq_q && st_q == MQRPS_ST_IDLE |-> q_rd == '0)
        else $error("null queue read");
    a_no_read: assert property (st_q == MQRPS_ST_IDLE && ov_q && (read_en_n || output_en_n)
        |=> $stable(dout_q)) else $error("data moved without enable");
    a_sector_sel: assert property (!polled_flag_mode && flag_sector_strobe && addr_mine
        |=> sec_q == $past(read_address_bus[0])) else $error("sector select");
    a_poll_step: assert property (polled_flag_mode && $past(polled_flag_mode) && $past(rst_n)
        |-> sec_q != $past(sec_q)) else $error("poll stuck");
    a_pr_mode: assert property (!packet_mode |=> packet_ready_flag_n)
        else $error("packet ready outside packet mode");

    // ----------------------------------------------------------------
    // check helpers
    // ----------------------------------------------------------------
    // cycles since the last queue selection, saturating; read by checks only
    logic [1:0] sel_age_q, sel_age_d;

    always_comb begin
        sel_age_d = sel_age_q;
        if (read_queue_select_strobe) begin
            sel_age_d = 2'd0;
        end else if (sel_age_q != 2'd3) begin
            sel_age_d = sel_age_q + 2'd1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sel_age_q <= 2'd3;
        end else begin
            sel_age_q <= sel_age_d;
        end
    end

    // timing seen from the selection edge, not from the state register
    a_old_age: assert property (sel_age_q == 2'd0 |-> st_q == MQRPS_ST_OLD)
        else $error("old queue slot missed");
    a_age_new: assert property (sel_age_q == 2'd1 |-> st_q == MQRPS_ST_NEW)
        else $error("new queue slot missed");
    a_first_word_fallthrough_due: assert property (sel_age_q == 2'd2 && mine_q && !nullq_q
        && $past(lvl[rq_q]) != '0 |-> !output_valid_flag_n && q_out == $past(head[rq_q]))
        else $error("first word not shown");
    a_read_word: assert property (st_q == MQRPS_ST_IDLE && mine_q && !nullq_q
        && !read_en_n && !output_en_n && lvl[rq_q] != '0 |=> q_out == $past(head[rq_q]))
        else $error("enabled read lost");
    a_ov_empty: assert property (st_q == MQRPS_ST_IDLE && mine_q && !nullq_q && !ov_q
        && lvl[rq_q] == '0 |=> output_valid_flag_n) else $error("valid from empty queue");
    a_sel_keep: assert property (!read_queue_select_strobe
        |=> $stable(rq_q) && $stable(nullq_q)) else $error("queue moved without strobe");

    // deselected device and null queue stay quiet
    a_unsel_quiet: assert property (!mine_q |-> q_rd == '0 && !q_out_oe)
        else $error("unselected device active");
    a_unsel_ov: assert property (!mine_q |=> output_valid_flag_n)
        else $error("unselected device valid");
    a_null_ov: assert property (nullq_q && st_q != MQRPS_ST_OLD
        |=> output_valid_flag_n) else $error("null queue valid");
    a_null_flags: assert property (nullq_q
        |=> almost_empty_flag_n && packet_ready_flag_n) else $error("null queue flagged");

    // discrete flags, token and poll sync
    a_ae_flag: assert property (!nullq_q && ae_vec[rq_q] |=> !almost_empty_flag_n)
        else $error("almost empty missed");
    a_pr_low: assert property (packet_mode && !nullq_q && pr_vec[rq_q]
        |=> !packet_ready_flag_n) else $error("packet ready missed");
    a_sec_keep: assert property (!polled_flag_mode && !flag_sector_strobe
        |=> $stable(sec_q)) else $error("sector moved without strobe");
    a_tok_follow: assert property ($past(rst_n)
        |-> expansion_token_out == $past(expansion_token_in)) else $error("token lag");
    a_sync_sector: assert property (polled_flag_mode && $past(polled_flag_mode)
        && $past(rst_n) |-> flag_poll_sync == !sec_q) else $error("sync off sector");

    c_select: cover property (read_queue_select_strobe ##2 st_q == MQRPS_ST_NEW);
    c_null: cover property (read_queue_select_strobe && read_address_bus[4]);
    c_sector: cover property (flag_sector_strobe && addr_mine);
    c_read: cover property (!read_en_n && !output_en_n && ov_q);
    c_packet: cover property (packet_mode && !packet_ready_flag_n);
endmodule

// file: rtl/mqrps_defines.svh
// constants of the read-port select block: address fields, widths, counts
// assumes inclusion by the package and the design modules only
//
// Behaviour
// - word output with enables low or output stale, and on two edges after selection; queue selected
// - packet mode uses top four bits as markers
// - strobe high captures address as read queue
// - low four address bits index sixteen queues
// - address bit four selects the null queue
// - top three bits must match device code
// - next edge shows previous queue regardless enable
// - second edge shows new queue first word
// - strobed flags: bit zero picks the sector
// - flag strobe captures sector bit when device bits match
// - polled flags step sectors, sync on clock
// - flags and tokens update on read clock
// - queue selection ignores read enable level
// - packet ready low when complete packet held
`ifndef MQRPS_DEFINES_SVH
`define MQRPS_DEFINES_SVH

// ----------------------------------------------------------------
// address bus fields, widths, counts and levels
// ----------------------------------------------------------------
`define MQRPS_ADDR_W      8
`define MQRPS_QIDX_MSB    3
`define MQRPS_NULL_BIT    4
`define MQRPS_DEV_LSB     5
`define MQRPS_DEV_MSB     7
`define MQRPS_NUM_QUEUES  16
`define MQRPS_DATA_W      36
`define MQRPS_MARK_LSB    32
`define MQRPS_FLAG_W      8
`define MQRPS_NUM_SECTORS 2
`define MQRPS_QDEPTH      16
`define MQRPS_PTR_W       4
`define MQRPS_AE_LEVEL    5'h02

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MQRPS_RST_QIDX    4'h0
`define MQRPS_RST_FLAGS   8'hFF

`endif

// file: rtl/mqrps_pkg.sv
// types shared by the read-port select design
// assumes the defines header is on the include path
`include "mqrps_defines.svh"

package mqrps_pkg;
    // read-side output pipeline after a queue change
    typedef enum logic [2:0] {
        MQRPS_ST_IDLE = 3'b001,
        MQRPS_ST_OLD  = 3'b010,
        MQRPS_ST_NEW  = 3'b100
    } mqrps_sel_t;
endpackage

// file: rtl/mqrps_queue.sv
// one queue: storage, read pointer, occupancy and packet count
// assumes the caller writes only when not full and reads only when not empty
`timescale 1ns/1ps
`include "mqrps_defines.svh"

module mqrps_queue
    import mqrps_pkg::*;
(
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    // fill side
    input  wire logic                     wr_en,
    input  wire logic [`MQRPS_DATA_W-1:0] wr_data,
    input  wire logic                     wr_eop,
    // drain side
    input  wire logic                     rd_en,
    input  wire logic                     rd_eop,
    output logic      [`MQRPS_DATA_W-1:0] head_data,
    output logic      [`MQRPS_PTR_W:0]    level,
    output logic                          pkt_avail
);
    logic [`MQRPS_DATA_W-1:0] mem_q [`MQRPS_QDEPTH];
    logic [`MQRPS_PTR_W-1:0]  wp_q, wp_d, rp_q, rp_d;
    logic [`MQRPS_PTR_W:0]    lvl_q, lvl_d, pk_q, pk_d;

    // pointers and counts; read and write may coincide
    always_comb begin
        wp_d  = wp_q + `MQRPS_PTR_W'(wr_en);
        rp_d  = rp_q + `MQRPS_PTR_W'(rd_en);
        lvl_d = lvl_q + (`MQRPS_PTR_W+1)'(wr_en) - (`MQRPS_PTR_W+1)'(rd_en);
        pk_d  = pk_q + (`MQRPS_PTR_W+1)'(wr_en & wr_eop)
                     - (`MQRPS_PTR_W+1)'(rd_en & rd_eop);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            lvl_q <= '0;
            pk_q  <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            lvl_q <= lvl_d;
            pk_q  <= pk_d;
        end
    end

    // storage has no reset; contents are meaningless while empty
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_q[wp_q] <= wr_data;
        end
    end

    assign head_data = mem_q[rp_q];
    assign level     = lvl_q;
    assign pkt_avail = (pk_q != '0);
endmodule

// file: verification/mqrps_reader.sv
// reading-logic model: queue and sector strobes, address bus, enables
// assumes the bench owns the read clock and calls the tasks below
`timescale 1ns/1ps

module mqrps_reader (
    // clock
    input  wire logic       clk_sys,
    // reader controls
    output logic            read_queue_select_strobe,
    output logic            flag_sector_strobe,
    output logic [7:0]      read_address_bus,
    output logic            read_en_n,
    output logic            output_en_n,
    output logic            serial_load_done_out
);
    // idle levels; load-done starts high as if programming were running
    initial begin
        read_queue_select_strobe = 1'b0;
        flag_sector_strobe       = 1'b0;
        read_address_bus         = 8'h00;
        read_en_n                = 1'b1;
        output_en_n              = 1'b0;
        serial_load_done_out     = 1'b1;
        repeat (4) @(posedge clk_sys);
        serial_load_done_out <= 1'b0;
    end

    // enables change just after an edge and hold to the next one
    task automatic set_en(input logic ren, input logic oen);
        @(posedge clk_sys);
        read_en_n   <= ren;
        output_en_n <= oen;
    endtask

    // one strobe for one cycle; the other strobe stays low throughout
    task automatic pulse(input logic flags, input logic [7:0] addr);
        for (int i = 0; i < 8 && serial_load_done_out !== 1'b0; i++)
            @(posedge clk_sys);
        @(posedge clk_sys);
        read_queue_select_strobe <= ~flags;
        flag_sector_strobe       <= flags;
        read_address_bus         <= addr;
        @(posedge clk_sys);
        read_queue_select_strobe <= 1'b0;
        flag_sector_strobe       <= 1'b0;
        read_address_bus         <= ~addr; // stale address must not matter
    endtask
endmodule

// file: verification/multi_queue_read_port_select_bench.sv
// bench for the read-port select block: fallthrough, null, cascade, flags
// assumes the reader model in its own file and the design under rtl/
`timescale 1ns/1ps

module multi_queue_read_port_select_bench;
    import mqrps_pkg::*;
    localparam logic [2:0] DEV = 3'h2;
    logic        clk_sys, rst_n, polled, wr_en, tok_in, pkt;
    logic [3:0]  wr_queue;
    logic [35:0] wr_data, q_out;
    logic [7:0]  addr, ae_bus, pr_bus;
    logic        sel_stb, sec_stb, ren_n, oen_n, load_done, oe, ov_n, ae_n, pr_n, sync, tok;
    int          fails, total_checks;

    // free-running read clock, never gated
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    mqrps_reader reader_u (.clk_sys(clk_sys), .read_queue_select_strobe(sel_stb),
        .flag_sector_strobe(sec_stb), .read_address_bus(addr), .read_en_n(ren_n),
        .output_en_n(oen_n), .serial_load_done_out(load_done));

    mqrps_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .device_id(DEV), .packet_mode(pkt),
        .polled_flag_mode(polled), .serial_load_done_out(load_done), .wr_en(wr_en),
        .wr_queue(wr_queue), .wr_data(wr_data), .read_queue_select_strobe(sel_stb),
        .flag_sector_strobe(sec_stb), .read_address_bus(addr), .read_en_n(ren_n),
        .output_en_n(oen_n), .expansion_token_in(tok_in), .q_out(q_out), .q_out_oe(oe),
        .output_valid_flag_n(ov_n), .almost_empty_flag_n(ae_n), .packet_ready_flag_n(pr_n),
        .almost_empty_flag_bus(ae_bus), .packet_ready_flag_bus(pr_bus),
        .flag_poll_sync(sync), .expansion_token_out(tok));

    // -----------------------------------------------------------------
    // shared helpers
    // -----------------------------------------------------------------
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [35:0] word(input logic [3:0] q, input logic [7:0] i);
        return {4'h0, 20'h0_0000, q, i};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // reset values are looked at while reset is still held
    task automatic do_reset(input logic poll, input logic pk);
        @(posedge clk_sys);
        rst_n  <= 1'b0;
        polled <= poll;
        pkt    <= pk;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({ae_bus, pr_bus, ov_n, sync, tok}, {16'hFFFF, 3'b100});
        @(posedge clk_sys);
        rst_n <= 1'b1;
        tick(1);
    endtask

    task automatic fill(input logic [3:0] q, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            wr_en    <= 1'b1;
            wr_queue <= q;
            wr_data  <= word(q, 8'(i));
        end
        @(posedge clk_sys);
        wr_en <= 1'b0;
        tick(2);
    endtask

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_reset();
        chk(q_out, 36'h0_0000_0000);
        chk({ov_n, sync, tok}, 3'b100);
        chk({ae_bus, pr_bus}, 16'h00FF);
    endtask

    // select with read enable high, then hold, then one enabled read
    task automatic t_select();
        fill(4'h3, 3);
        fill(4'h6, 5);
        reader_u.pulse(1'b0, {DEV, 1'b0, 4'h3});
        for (int i = 0; i < 6 && ov_n !== 1'b0; i++) tick(1);
        chk(q_out, word(4'h3, 8'h00));
        chk(oe, 1'b1);
        tick(3);
        chk(q_out, word(4'h3, 8'h00));
        reader_u.set_en(1'b0, 1'b0);
        reader_u.set_en(1'b1, 1'b0);
        tick(2);
        chk(q_out, word(4'h3, 8'h01));
        chk(ae_n, 1'b0);
    endtask

    // a queue change must drain one old word before the new head appears
    task automatic t_change();
        logic old_seen;
        old_seen = 1'b0;
        reader_u.pulse(1'b0, {DEV, 1'b0, 4'h6});
        for (int i = 0; i < 6 && q_out !== word(4'h6, 8'h00); i++) begin
            if (q_out === word(4'h3, 8'h02)) old_seen = 1'b1;
            tick(1);
        end
        chk(old_seen, 1'b1);
        chk(q_out, word(4'h6, 8'h00));
    endtask

    // null queue: reads enabled, but once the old queue word drains nothing valid comes out
    task automatic t_null();
        reader_u.pulse(1'b0, {DEV, 1'b1, 4'h6});
        reader_u.set_en(1'b0, 1'b0);
        tick(4);
        chk(ov_n, 1'b1);
        reader_u.set_en(1'b1, 1'b0);
    endtask

    // sector bit zero only; bits four to one set to prove they are ignored
    task automatic t_sector();
        reader_u.pulse(1'b1, {DEV, 4'hF, 1'b0});
        tick(2);
        chk(ae_bus, 8'h40);
        chk(pr_bus, 8'hFF);
        reader_u.pulse(1'b1, {DEV, 4'h0, 1'b1});
        tick(2);
        chk(ae_bus, 8'h00);
        reader_u.pulse(1'b1, {DEV + 3'h1, 4'h0, 1'b0});
        tick(2);
        chk(ae_bus, 8'h00);
    endtask

    // another device's code: outputs released and nothing valid
    task automatic t_other_dev();
        reader_u.pulse(1'b0, {DEV + 3'h1, 1'b0, 4'h6});
        tick(4);
        chk({oe, ov_n}, 2'b01);
        @(posedge clk_sys);
        tok_in <= 1'b1;
        tick(2);
        chk(tok, 1'b1);
    endtask

    // polled mode: sync pulses while the sectors alternate
    task automatic t_polled();
        int highs;
        highs = 0;
        do_reset(1'b1, 1'b0);
        fill(4'h2, 3);
        for (int i = 0; i < 6; i++) begin
            tick(1);
            highs += int'(sync === 1'b1);
            chk(ae_bus, (sync === 1'b1) ? 8'h04 : 8'h00);
        end
        chk(highs == 3, 1'b1);
    endtask

    // packet mode: markers ride in the top bits, packet ready follows the queue
    task automatic t_packet();
        do_reset(1'b0, 1'b1);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            wr_en    <= 1'b1;
            wr_queue <= 4'h5;
            wr_data  <= word(4'h5, 8'(i)) | {2'b00, i == 1, i == 0, 32'h0000_0000};
        end
        @(posedge clk_sys);
        wr_en <= 1'b0;
        tick(2);
        chk({ae_bus, pr_bus, pr_n}, {16'hFFDF, 1'b1});
        reader_u.pulse(1'b0, {DEV, 1'b0, 4'h5});
        for (int i = 0; i < 6 && ov_n !== 1'b0; i++) tick(1);
        chk(q_out, word(4'h5, 8'h00) | {4'h1, 32'h0000_0000});
        chk(pr_n, 1'b0);
        reader_u.set_en(1'b0, 1'b0);
        reader_u.set_en(1'b1, 1'b0);
        tick(2);
        chk(q_out, word(4'h5, 8'h01) | {4'h2, 32'h0000_0000});
        chk(pr_n, 1'b1);
    endtask

    // cut a hang short
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        end_sim();
    end

    initial begin
        rst_n        = 1'b0;
        polled       = 1'b0;
        wr_en        = 1'b0;
        wr_queue     = 4'h0;
        wr_data      = 36'h0_0000_0000;
        tok_in       = 1'b0;
        pkt          = 1'b0;
        fails        = 0;
        total_checks = 0;
        do_reset(1'b0, 1'b0);
        t_reset();
        t_select();
        t_change();
        t_null();
        t_sector();
        t_other_dev();
        t_polled();
        t_packet();
        end_sim();
    end
endmodule
